// [verilog/pms_pkg.sv]
// Package for the programmable Mealy sequencer: array sizes, field layout, reset values.
// Assumes one 20 MHz core clock; fuse contents arrive as static configuration inputs.
package pms_pkg;
   // ==========================================================
   // Array dimensions
   localparam int NUM_INPUTS   = 16;
   localparam int NUM_STATE    = 6;
   localparam int NUM_OUTPUTS  = 8;
   localparam int NUM_PTERMS   = 48;
   localparam int NUM_SUMPAIRS = NUM_STATE + NUM_OUTPUTS;
   // Operands of a product term: inputs, state feedback, complemented sum term
   localparam int NUM_OPERANDS = NUM_INPUTS + NUM_STATE + 1;
   localparam int OPD_STATE_LSB = NUM_INPUTS;
   localparam int OPD_CTERM_POS = NUM_INPUTS + NUM_STATE;
   // Each operand has a true and a complement link
   localparam int AND_LINKS    = 2 * NUM_OPERANDS;
   // ==========================================================
   // Reset and diagnostic values
   localparam logic [NUM_STATE-1:0]   STATE_PRESET = 6'h3F;
   localparam logic [NUM_OUTPUTS-1:0] OUT_PRESET   = 8'hFF;
   localparam logic [1:0]             DIAG_HIGH    = 2'h3;
   localparam int DIAG_INPUT_LINE = 0;
   // Clock
   localparam int CLK_PERIOD_NS = 50;

   // Fuse map carried as one bundle
   typedef struct packed {
      logic [NUM_PTERMS-1:0][AND_LINKS-1:0]     and_intact;
      logic [NUM_SUMPAIRS-1:0][NUM_PTERMS-1:0]  set_intact;
      logic [NUM_SUMPAIRS-1:0][NUM_PTERMS-1:0]  rst_intact;
      logic [NUM_PTERMS-1:0]                    cterm_intact;
      logic                                     oe_mode;
   } pms_fuse_type;

   // One set/reset pair per register bit
   typedef struct packed {
      logic [NUM_SUMPAIRS-1:0] set_term;
      logic [NUM_SUMPAIRS-1:0] rst_term;
   } pms_sum_type;
endpackage

// [verilog/pms_and_term.sv]
// One product term of the AND array.
// Assumes link vectors hold 1 for an intact link; a blown link floats high.
`timescale 1ns/100ps
`default_nettype none
module pms_and_term #(
   parameter int NUM_OPD = 23
) (
   // Operands and link map
   input  wire logic [NUM_OPD-1:0]   opd_i,
   input  wire logic [2*NUM_OPD-1:0] intact_i,
   // Product
   output logic                      prod_o
);
   wire [2*NUM_OPD-1:0] lit_w = {~opd_i, opd_i};
   // Blown links read high so they drop out of the AND
   wire [2*NUM_OPD-1:0] gated_w = lit_w | ~intact_i;
   assign prod_o = &gated_w;

   initial begin
      if (NUM_OPD < 1) $error("NUM_OPD must be positive");
   end
endmodule // pms_and_term
`default_nettype wire

// [verilog/pms_or_term.sv]
// One sum term of the OR array.
// Assumes link vector holds 1 for an intact link; a blown link floats low.
`timescale 1ns/100ps
`default_nettype none
module pms_or_term #(
   parameter int NUM_PT = 48
) (
   // Products and link map
   input  wire logic [NUM_PT-1:0] prod_i,
   input  wire logic [NUM_PT-1:0] intact_i,
   // Sum
   output logic                   sum_o
);
   // Blown links read low so the product does not contribute
   assign sum_o = |(prod_i & intact_i);

   initial begin
      if (NUM_PT < 1) $error("NUM_PT must be positive");
   end
endmodule // pms_or_term
`default_nettype wire

// [verilog/pms_sequencer.sv]
// Top of the programmable Mealy sequencer: AND/OR arrays, state and output registers,
// shared preset / output-enable pin and diagnostic view.
// Assumes inputs synchronous to core_clk_i; fuse map static during operation;
// the 10 V diagnostic level is reported by the pad as a plain logic flag.
`timescale 1ns/100ps
`default_nettype none
module pms_sequencer #(
   parameter int NUM_PT = pms_pkg::NUM_PTERMS
) (
   // Clock and reset
   input  wire logic                           core_clk_i,
   input  wire logic                           rst_i,
   // Fuse map
   input  wire pms_pkg::pms_fuse_type          fuse_i,
   // External pins
   input  wire logic [pms_pkg::NUM_INPUTS-1:0] external_input_lines_i,
   input  wire logic                           diag_level_i,
   input  wire logic                           preset_oe_i,
   // Registered outputs
   output logic [pms_pkg::NUM_OUTPUTS-1:0]     registered_output_lines_o,
   output logic [pms_pkg::NUM_OUTPUTS-1:0]     registered_output_oe_o
);
   // ==========================================================
   // Control pin decode
   // Fuse selects the pin role
   wire preset_w = ~fuse_i.oe_mode & preset_oe_i;
   wire oe_w     = ~(fuse_i.oe_mode & preset_oe_i);
   // Async clear of the flops doubles as preset; register reset value is all ones
   wire force_w  = rst_i | preset_w;

   // ==========================================================
   // Registers
   logic [pms_pkg::NUM_STATE-1:0]   state_feedback_bits_q;
   logic [pms_pkg::NUM_STATE-1:0]   state_d;
   logic [pms_pkg::NUM_OUTPUTS-1:0] outreg_q;
   logic [pms_pkg::NUM_OUTPUTS-1:0] outreg_d;
   logic [pms_pkg::NUM_OUTPUTS-1:0] pin_q;
   logic [pms_pkg::NUM_OUTPUTS-1:0] pin_d;
   logic [pms_pkg::NUM_OUTPUTS-1:0] oe_q;

   // ==========================================================
   // AND array
   wire [NUM_PT-1:0] prod_w;
   wire              cterm_w;
   // Operands: inputs, fed-back state and complemented sum term
   wire [pms_pkg::NUM_OPERANDS-1:0] opd_w =
      {~cterm_w, state_feedback_bits_q, external_input_lines_i};

   genvar gp;
   generate
      for (gp = 0; gp < NUM_PT; gp++) begin : g_and
         pms_and_term #(.NUM_OPD(pms_pkg::NUM_OPERANDS)) u_and (
            .opd_i    (opd_w),
            .intact_i (fuse_i.and_intact[gp]),
            .prod_o   (prod_w[gp])
         );

         AST_AND_ALL_BLOWN: assert property (@(posedge core_clk_i)
            (fuse_i.and_intact[gp] == '0) |-> prod_w[gp])
            else $error("product with every link blown is not high");
      end
   endgenerate

   // ==========================================================
   // OR array
   pms_pkg::pms_sum_type sum_w;

   pms_or_term #(.NUM_PT(NUM_PT)) u_cterm (
      .prod_i   (prod_w),
      .intact_i (fuse_i.cterm_intact),
      .sum_o    (cterm_w)
   );

   genvar gs;
   generate
      for (gs = 0; gs < pms_pkg::NUM_SUMPAIRS; gs++) begin : g_or
         pms_or_term #(.NUM_PT(NUM_PT)) u_set (
            .prod_i   (prod_w),
            .intact_i (fuse_i.set_intact[gs]),
            .sum_o    (sum_w.set_term[gs])
         );
         pms_or_term #(.NUM_PT(NUM_PT)) u_rst (
            .prod_i   (prod_w),
            .intact_i (fuse_i.rst_intact[gs]),
            .sum_o    (sum_w.rst_term[gs])
         );

         AST_OR_ALL_BLOWN: assert property (@(posedge core_clk_i)
            (fuse_i.set_intact[gs] == '0) |-> !sum_w.set_term[gs])
            else $error("sum with every link blown is not low");
      end
   endgenerate

   // ==========================================================
   // Set/reset next values
   // Pairs 0-5 steer state, 6-13 steer outputs
   wire [pms_pkg::NUM_STATE-1:0] st_set_w = sum_w.set_term[pms_pkg::NUM_STATE-1:0];
   wire [pms_pkg::NUM_STATE-1:0] st_rst_w = sum_w.rst_term[pms_pkg::NUM_STATE-1:0];
   wire [pms_pkg::NUM_OUTPUTS-1:0] q_set_w =
      sum_w.set_term[pms_pkg::NUM_SUMPAIRS-1:pms_pkg::NUM_STATE];
   wire [pms_pkg::NUM_OUTPUTS-1:0] q_rst_w =
      sum_w.rst_term[pms_pkg::NUM_SUMPAIRS-1:pms_pkg::NUM_STATE];

   // S/R: S=R=1 toggles, as a JK-style S/R cell would; S=R=0 holds
   assign state_d  = (st_set_w & ~st_rst_w) | (~st_set_w & ~st_rst_w & state_feedback_bits_q)
                   | (st_set_w & st_rst_w & ~state_feedback_bits_q);
   assign outreg_d = (q_set_w & ~q_rst_w) | (~q_set_w & ~q_rst_w & outreg_q)
                   | (q_set_w & q_rst_w & ~outreg_q);

   // Diagnostic view works on the pin copy only
   wire [pms_pkg::NUM_OUTPUTS-1:0] diag_view_w = {pms_pkg::DIAG_HIGH, state_d};
   assign pin_d = diag_level_i ? diag_view_w : outreg_d;

   // ==========================================================
   // Register updates; preset is constant-valued async and clear wins until release
   always_ff @(posedge core_clk_i or posedge force_w) begin
      if (force_w) begin
         state_feedback_bits_q <= pms_pkg::STATE_PRESET;
         outreg_q              <= pms_pkg::OUT_PRESET;
      end else begin
         // First edge after release updates with no extra edge needed
         state_feedback_bits_q <= state_d;
         outreg_q              <= outreg_d;
      end
   end

   always_ff @(posedge core_clk_i or posedge force_w) begin
      if (force_w) begin
         pin_q <= pms_pkg::OUT_PRESET;
      end else begin
         pin_q <= pin_d;
      end
   end

   // Enable is registered so the top outputs all come from flops; costs one cycle
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         oe_q <= '1;
      end else begin
         oe_q <= {pms_pkg::NUM_OUTPUTS{oe_w}};
      end
   end

   assign registered_output_lines_o = pin_q;
   assign registered_output_oe_o    = oe_q;

   // ==========================================================
   // Checks
   initial begin
      if (NUM_PT != pms_pkg::NUM_PTERMS) $error("NUM_PT must match fuse map width");
   end

   // Per-bit masks of the set/reset cases, kept as plain wires so $past sees signals.
   // Checks start only where force was low at the sampling edge: a release edge loads presets.
   wire [pms_pkg::NUM_OUTPUTS-1:0] chk_q_set_w   = q_set_w & ~q_rst_w;
   wire [pms_pkg::NUM_OUTPUTS-1:0] chk_q_clr_w   = ~q_set_w & q_rst_w;
   wire [pms_pkg::NUM_OUTPUTS-1:0] chk_q_hold_w  = ~q_set_w & ~q_rst_w;
   wire [pms_pkg::NUM_OUTPUTS-1:0] chk_q_tgl_w   = q_set_w & q_rst_w;
   wire [pms_pkg::NUM_STATE-1:0]   chk_st_set_w  = st_set_w & ~st_rst_w;
   wire [pms_pkg::NUM_STATE-1:0]   chk_st_clr_w  = ~st_set_w & st_rst_w;
   wire [pms_pkg::NUM_STATE-1:0]   chk_st_hold_w = ~st_set_w & ~st_rst_w;

   AST_PRESET_HOLDS: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (~fuse_i.oe_mode & preset_oe_i) |->
         (state_feedback_bits_q == pms_pkg::STATE_PRESET && outreg_q == pms_pkg::OUT_PRESET))
      else $error("preset did not hold registers high");

   AST_PRESET_PINS: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (~fuse_i.oe_mode & preset_oe_i) |-> registered_output_lines_o == pms_pkg::OUT_PRESET)
      else $error("preset did not force output pins high");

   AST_RESUME: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (~fuse_i.oe_mode && $fell(preset_oe_i)) |=> state_feedback_bits_q == $past(state_d))
      else $error("no update on first edge after preset release");

   AST_STATE_NEXT: assert property (@(posedge core_clk_i) disable iff (force_w)
      ##1 (!$past(force_w)) |-> state_feedback_bits_q == $past(state_d))
      else $error("state register missed its next value");

   AST_SET_ONLY: assert property (@(posedge core_clk_i) disable iff (force_w)
      (!force_w && q_set_w[0] && !q_rst_w[0]) ##1 !force_w |-> outreg_q[0])
      else $error("set term did not set output bit");

   AST_RST_ONLY: assert property (@(posedge core_clk_i) disable iff (force_w)
      (!force_w && st_rst_w[0] && !st_set_w[0]) ##1 !force_w |-> !state_feedback_bits_q[0])
      else $error("reset term did not clear state bit");

   AST_DIAG_VIEW: assert property (@(posedge core_clk_i) disable iff (force_w)
      (!force_w && diag_level_i) ##1 !force_w |->
         registered_output_lines_o == {pms_pkg::DIAG_HIGH, state_feedback_bits_q})
      else $error("diagnostic view wrong");

   AST_DIAG_KEEP: assert property (@(posedge core_clk_i) disable iff (force_w)
      (!force_w && diag_level_i ##1 !diag_level_i) |=>
         registered_output_lines_o == outreg_q)
      else $error("output register lost across diagnostic view");

   AST_OE_MODE: assert property (@(posedge core_clk_i) disable iff (rst_i)
      fuse_i.oe_mode |=> registered_output_oe_o == {pms_pkg::NUM_OUTPUTS{~$past(preset_oe_i)}})
      else $error("output enable does not follow pin");

   AST_PRESET_ENABLED: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !fuse_i.oe_mode |=> registered_output_oe_o == '1)
      else $error("outputs disabled in preset mode");

   // Set/reset cell behaviour, bit by bit
   AST_OUT_NEXT: assert property (@(posedge core_clk_i) disable iff (force_w)
      ##1 (!$past(force_w)) |->
         outreg_q == $past(outreg_d))
      else $error("output register missed its next value");

   AST_OUT_SET: assert property (@(posedge core_clk_i) disable iff (force_w)
      (!force_w && chk_q_set_w != '0) |=>
         ((outreg_q & $past(chk_q_set_w)) == $past(chk_q_set_w)))
      else $error("set-only output bit not set");

   AST_OUT_CLR: assert property (@(posedge core_clk_i) disable iff (force_w)
      (!force_w && chk_q_clr_w != '0) |=>
         ((outreg_q & $past(chk_q_clr_w)) == '0))
      else $error("reset-only output bit not cleared");

   AST_OUT_HOLD: assert property (@(posedge core_clk_i) disable iff (force_w)
      (!force_w && chk_q_hold_w != '0) |=>
         (((outreg_q ^ $past(outreg_q)) & $past(chk_q_hold_w)) == '0))
      else $error("output bit without set or reset changed");

   AST_OUT_TOGGLE: assert property (@(posedge core_clk_i) disable iff (force_w)
      (!force_w && chk_q_tgl_w != '0) |=>
         (((outreg_q ^ $past(outreg_q)) & $past(chk_q_tgl_w)) == $past(chk_q_tgl_w)))
      else $error("output bit with set and reset did not toggle");

   AST_ST_SET: assert property (@(posedge core_clk_i) disable iff (force_w)
      (!force_w && chk_st_set_w != '0) |=>
         ((state_feedback_bits_q & $past(chk_st_set_w)) == $past(chk_st_set_w)))
      else $error("set-only state bit not set");

   AST_ST_CLR: assert property (@(posedge core_clk_i) disable iff (force_w)
      (!force_w && chk_st_clr_w != '0) |=>
         ((state_feedback_bits_q & $past(chk_st_clr_w)) == '0))
      else $error("reset-only state bit not cleared");

   AST_ST_HOLD: assert property (@(posedge core_clk_i) disable iff (force_w)
      (!force_w && chk_st_hold_w != '0) |=>
         (((state_feedback_bits_q ^ $past(state_feedback_bits_q)) & $past(chk_st_hold_w)) == '0))
      else $error("state bit without set or reset changed");

   // Pin view, and output register update after preset release
   AST_PIN_NORMAL: assert property (@(posedge core_clk_i) disable iff (force_w)
      (!force_w && !diag_level_i) |=>
         registered_output_lines_o == outreg_q)
      else $error("pins do not show the output register");

   AST_DIAG_TOP: assert property (@(posedge core_clk_i) disable iff (force_w)
      (!force_w && diag_level_i) |=>
         registered_output_lines_o[7:6] == pms_pkg::DIAG_HIGH)
      else $error("upper pins not high in diagnostic view");

   AST_RESUME_OUT: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (~fuse_i.oe_mode && $fell(preset_oe_i)) |=>
         outreg_q == $past(outreg_d))
      else $error("output register idle on first edge after preset release");

   // Reset and output enable
   AST_RESET_FORCES: assert property (@(posedge core_clk_i)
      (rst_i ##1 rst_i) |-> (state_feedback_bits_q == pms_pkg::STATE_PRESET &&
         outreg_q == pms_pkg::OUT_PRESET && registered_output_lines_o == pms_pkg::OUT_PRESET))
      else $error("reset did not force registers high");

   AST_OE_RESET: assert property (@(posedge core_clk_i)
      (rst_i ##1 rst_i) |->
         registered_output_oe_o == '1)
      else $error("outputs not driven during reset");

   AST_OE_FLOAT: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (fuse_i.oe_mode && preset_oe_i) |=>
         registered_output_oe_o == '0)
      else $error("outputs still driven with control pin high");

   AST_OE_DRIVE: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (fuse_i.oe_mode && !preset_oe_i) |=>
         registered_output_oe_o == '1)
      else $error("outputs not driven with control pin low");

   AST_OE_RUNS: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (fuse_i.oe_mode && preset_oe_i) |=>
         (outreg_q == $past(outreg_d) && state_feedback_bits_q == $past(state_d)))
      else $error("registers stopped while outputs disabled");

   AST_PRESET_OE: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (!fuse_i.oe_mode && preset_oe_i) |->
         registered_output_oe_o == '1)
      else $error("preset pin disabled the outputs");
endmodule // pms_sequencer
`default_nettype wire

// [bench/pms_sys_pads.sv]
// System-side model of the output pads: resolves the three-state pins.
// Assumes one pad per output bit and no pull resistor on the board.
`timescale 1ns/100ps
`default_nettype none
module pms_sys_pads (
   // Clock
   input  wire logic                            core_clk_i,
   // Device side
   input  wire logic [pms_pkg::NUM_OUTPUTS-1:0] lines_i,
   input  wire logic [pms_pkg::NUM_OUTPUTS-1:0] oe_i,
   // Board side
   output logic [pms_pkg::NUM_OUTPUTS-1:0]      pins_o
);
   // ==========================================================
   // Pad resolution
   logic [pms_pkg::NUM_OUTPUTS-1:0] last_q;
   always_ff @(posedge core_clk_i) begin
      last_q <= pins_o;
   end
   // A released pad shows the inverse of its last level, so a float never passes
   always_comb begin
      for (int b = 0; b < pms_pkg::NUM_OUTPUTS; b++) begin
         pins_o[b] = oe_i[b] ? lines_i[b] : ~last_q[b];
      end
   end
endmodule // pms_sys_pads
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench: copy-style fuse map, reset, row loop, then diagnostic,
// preset and output-enable cases. Assumes the package and pad model compile first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
   $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module testbench;
   logic                 core_clk_i = 1'b0;
   logic                 rst_i      = 1'b1;
   pms_pkg::pms_fuse_type fuse;
   logic [15:0]          ext_in     = 16'h0000;
   logic                 diag       = 1'b0;
   logic                 preset     = 1'b0;
   logic [7:0]           lines;
   logic [7:0]           oe;
   logic [7:0]           pins;
   int                   error_cnt  = 0;
   int                   checked    = 0;
   // Out 0-6 copy inputs 6-12, state copies inputs 0-5, out 7 = state0 & input 15
   logic [15:0] row_in  [7] = '{16'h0001, 16'h8000, 16'h8FC0, 16'h9FFF, 16'hFFFE,
                                16'h8055, 16'h8000};
   logic [7:0]  row_exp [7] = '{8'h00, 8'h80, 8'h3F, 8'h7F, 8'hFF, 8'h01, 8'h80};

   pms_sequencer u_pms_sequencer (
      .core_clk_i               (core_clk_i),
      .rst_i                    (rst_i),
      .fuse_i                   (fuse),
      .external_input_lines_i   (ext_in),
      .diag_level_i             (diag),
      .preset_oe_i              (preset),
      .registered_output_lines_o(lines),
      .registered_output_oe_o   (oe)
   );
   pms_sys_pads u_pms_sys_pads (
      .core_clk_i(core_clk_i),
      .lines_i   (lines),
      .oe_i      (oe),
      .pins_o    (pins)
   );

   initial begin
      forever #25 core_clk_i = ~core_clk_i;
   end

   task automatic report_and_stop;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic apply(input logic [15:0] v);
      @(posedge core_clk_i) ext_in <= v;
      @(posedge core_clk_i);
      #1;
   endtask

   // ==========================================================
   // Watchdog: the sequence needs well under 100 cycles
   initial begin
      #(2000 * 50);
      error_cnt++;
      report_and_stop();
   end

   // ==========================================================
   // Main sequence
   initial begin
      fuse = '0;
      for (int j = 0; j < 14; j++) begin
         fuse.and_intact[j][j]      = 1'b1;
         fuse.and_intact[14+j][23+j] = 1'b1;
      end
      for (int p = 0; p < 13; p++) begin
         fuse.set_intact[p][p]    = 1'b1;
         fuse.rst_intact[p][14+p] = 1'b1;
      end
      fuse.and_intact[28][16] = 1'b1;
      fuse.and_intact[28][15] = 1'b1;
      fuse.set_intact[13][28] = 1'b1;
      fuse.and_intact[31][15] = 1'b1;
      fuse.cterm_intact[31]   = 1'b1;
      fuse.and_intact[29][22] = 1'b1;
      fuse.and_intact[30][39] = 1'b1;
      fuse.rst_intact[13][29] = 1'b1;
      fuse.rst_intact[13][30] = 1'b1;
      repeat (6) @(posedge core_clk_i);
      #1;
      `CHK(lines, 8'hFF)
      `CHK(oe, 8'hFF)
      @(posedge core_clk_i) rst_i <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         apply(row_in[i]);
         `CHK(lines, row_exp[i])
         `CHK(pins, row_exp[i])
      end
      // Diagnostic view, then back to the output register
      @(posedge core_clk_i) diag <= 1'b1;
      ext_in <= 16'h1FEA;
      @(posedge core_clk_i);
      #1;
      `CHK(lines, 8'hEA)
      @(posedge core_clk_i) diag <= 1'b0;
      @(posedge core_clk_i);
      #1;
      `CHK(lines, 8'h7F)
      // Preset forces high without a clock, then the first edge updates
      @(posedge core_clk_i) preset <= 1'b1;
      ext_in <= 16'h0000;
      #1;
      `CHK(lines, 8'hFF)
      @(posedge core_clk_i);
      #1;
      `CHK(lines, 8'hFF)
      @(posedge core_clk_i) preset <= 1'b0;
      ext_in <= 16'h8000;
      @(posedge core_clk_i);
      #1;
      `CHK(lines, 8'h80)
      // Output-enable mode after a second reset
      @(posedge core_clk_i) rst_i <= 1'b1;
      fuse.oe_mode <= 1'b1;
      @(posedge core_clk_i);
      #1;
      `CHK(lines, 8'hFF)
      @(posedge core_clk_i) rst_i <= 1'b0;
      @(posedge core_clk_i) preset <= 1'b1;
      ext_in <= 16'h0040;
      @(posedge core_clk_i);
      #1;
      `CHK(oe, 8'h00)
      `CHK(lines, 8'h01)
      @(posedge core_clk_i) preset <= 1'b0;
      @(posedge core_clk_i);
      #1;
      `CHK(oe, 8'hFF)
      `CHK(pins, 8'h01)
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
